// >>> src/gpc_pkg.sv
// shared constants for the port c mux and input qualification block
package gpc_pkg;
	// pin counts
	localparam int GPC_NPINS = 24;
	localparam int GPC_NDATA = 16;
	localparam int GPC_NADDR = 8;
	localparam int GPC_GROUP = 8;
	localparam int GPC_NGROUPS = 3;
	// register byte offsets
	localparam logic [7:0] GPC_OFS_FSEL_LOW = 8'h00;
	localparam logic [7:0] GPC_OFS_FSEL_HIGH = 8'h04;
	localparam logic [7:0] GPC_OFS_DIRECTION = 8'h08;
	localparam logic [7:0] GPC_OFS_PIN_VALUE = 8'h0c;
	localparam logic [7:0] GPC_OFS_QSEL_LOW = 8'h10;
	localparam logic [7:0] GPC_OFS_QSEL_HIGH = 8'h14;
	localparam logic [7:0] GPC_OFS_QUAL_CTRL = 8'h18;
	// reset values
	localparam logic [31:0] GPC_RST_FSEL_LOW = 32'h0000_0000;
	localparam logic [15:0] GPC_RST_FSEL_HIGH = 16'h0000;
	localparam logic [23:0] GPC_RST_DIRECTION = 24'h00_0000;
	localparam logic [23:0] GPC_RST_DOUT = 24'h00_0000;
	localparam logic [31:0] GPC_RST_QSEL_LOW = 32'h0000_0000;
	localparam logic [15:0] GPC_RST_QSEL_HIGH = 16'h0000;
	localparam logic [23:0] GPC_RST_QUAL_CTRL = 24'h00_0000;
	// field layout of the qualification control register
	localparam int GPC_PRD_WIDTH = 8;
	localparam int GPC_PRD_POS0 = 0;
	// level seen by the bus controller on a data line whose pin is not routed to it
	localparam logic [15:0] GPC_XD_DEFAULT = 16'h0000;
	// window lengths in samples
	localparam int GPC_WIN_SHORT = 3;
	localparam int GPC_WIN_LONG = 6;
	// qualification modes
	typedef enum logic [1:0] {
		GPC_Q_SYNC = 2'h0,
		GPC_Q_WIN3 = 2'h1,
		GPC_Q_WIN6 = 2'h2,
		GPC_Q_RAW = 2'h3
	} gpc_qmode_e;
endpackage : gpc_pkg

// >>> src/gpc_qualifier.sv
// one pin's input qualifier: sync only, 3- or 6-sample window, or raw pass-through
module gpc_qualifier
	import gpc_pkg::*;
(
	// clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// pin side
	input wire logic sync_in,
	input wire logic raw_in,
	// control
	input wire logic [1:0] qmode,
	input wire logic sample_tick,
	// result
	output logic qual_out
);

	logic [GPC_WIN_LONG-1:0] samples;
	logic held;
	logic all3_hi;
	logic all3_lo;
	logic all6_hi;
	logic all6_lo;

	// samples shift in once per programmed period
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			samples <= '0;
		end else if (sample_tick) begin
			samples <= {samples[GPC_WIN_LONG-2:0], sync_in};
		end
	end

	assign all3_hi = &samples[GPC_WIN_SHORT-1:0];
	assign all3_lo = ~|samples[GPC_WIN_SHORT-1:0];
	assign all6_hi = &samples;
	assign all6_lo = ~|samples;

	// in window modes the filtered level changes only on a unanimous window; in sync and raw modes it follows sync_in
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			held <= 1'b0;
		end else begin
			unique case (gpc_qmode_e'(qmode))
				GPC_Q_WIN3: begin
					if (all3_hi) held <= 1'b1;
					else if (all3_lo) held <= 1'b0;
				end
				GPC_Q_WIN6: begin
					if (all6_hi) held <= 1'b1;
					else if (all6_lo) held <= 1'b0;
				end
				GPC_Q_SYNC, GPC_Q_RAW: begin
					held <= sync_in;
				end
			endcase
		end
	end

	// output path per mode
	always_comb begin
		unique case (gpc_qmode_e'(qmode))
			GPC_Q_SYNC: qual_out = sync_in;
			GPC_Q_WIN3, GPC_Q_WIN6: qual_out = held;
			GPC_Q_RAW: qual_out = raw_in;
		endcase
	end
endmodule : gpc_qualifier

// >>> src/gpc_port.sv
// port c pin function mux, gpio input qualification and ahb-lite register slave
// Operation
// - pins 0-15 use low select field 2n+1:2n; 1x picks bidirectional data line 15-n.
// - pins 16-23 use high select field 2k+1:2k; 1x drives address line k.
// - every gpio pin has its own 2-bit qualification selector in two registers.
// - selector 00 only synchronises the input and is the reset value.
// - selectors 01 and 10 synchronise, then filter through a sampling window.
// - sample period comes from a control field, one per group of eight pins.
// - period sets the sample interval as a multiple of clock cycles.
// - window holds three or six consecutive samples depending on mode.
// - output changes only when all window samples agree; else it holds.
// - selector 11 passes the raw pin input with no synchronisation.
// - an unrouted peripheral input sits at a fixed default level.
// - input routing decides which selected pin drives each peripheral input.
//
// Decided for this implementation: register access over AHB-Lite and the register offsets.
module gpc_port
	import gpc_pkg::*;
(
	// clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// ahb-lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	// port c pins
	input wire logic [GPC_NPINS-1:0] pin_in,
	output logic [GPC_NPINS-1:0] pin_out,
	output logic [GPC_NPINS-1:0] pin_oe_n,
	// external bus controller
	input wire logic [GPC_NDATA-1:0] ext_bus_data_line_out,
	input wire logic ext_bus_data_drive,
	output logic [GPC_NDATA-1:0] ext_bus_data_line_in,
	input wire logic [GPC_NADDR-1:0] ext_bus_addr_line
);

	// registers
	logic [31:0] portc_function_select_low;
	logic [15:0] portc_function_select_high;
	logic [GPC_NPINS-1:0] portc_direction;
	logic [GPC_NPINS-1:0] portc_out_latch;
	logic [31:0] input_qual_selector_low;
	logic [15:0] input_qual_selector_high;
	logic [GPC_NGROUPS*GPC_PRD_WIDTH-1:0] port_qual_control;

	// bus state
	logic wr_pend;
	logic [7:0] wr_addr;
	logic addr_valid;
	logic [31:0] next_hrdata;

	// input paths
	logic [GPC_NPINS-1:0] sync1;
	logic [GPC_NPINS-1:0] sync2;
	logic [GPC_NPINS-1:0] portc_pin_value;
	logic [GPC_NPINS-1:0] ext_sel;
	logic [GPC_NGROUPS-1:0] grp_tick;
	logic [GPC_NPINS*2-1:0] qsel_all;

	// field of two bits for index idx
	function automatic logic [1:0] field2(input logic [31:0] word, input int idx);
		field2 = word[2*idx +: 2];
	endfunction : field2

	// sample interval in cycles: 1 for period 0, else twice the period
	function automatic logic [GPC_PRD_WIDTH:0] interval(input logic [GPC_PRD_WIDTH-1:0] prd);
		if (prd == '0) interval = {{GPC_PRD_WIDTH{1'b0}}, 1'b1};
		else interval = {prd, 1'b0};
	endfunction : interval

	// ahb-lite: zero wait state, always okay
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign addr_valid = hsel && htrans[1] && hready;

	// capture of write address phase
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend <= 1'b0;
			wr_addr <= 8'h00;
		end else begin
			wr_pend <= addr_valid && hwrite;
			wr_addr <= haddr[7:0];
		end
	end

	// read data chosen in the address phase and held in a register
	always_comb begin
		next_hrdata = 32'h0000_0000;
		unique case (haddr[7:0])
			GPC_OFS_FSEL_LOW: next_hrdata = portc_function_select_low;
			GPC_OFS_FSEL_HIGH: next_hrdata = {16'h0000, portc_function_select_high};
			GPC_OFS_DIRECTION: next_hrdata = {8'h00, portc_direction};
			GPC_OFS_PIN_VALUE: next_hrdata = {8'h00, portc_pin_value};
			GPC_OFS_QSEL_LOW: next_hrdata = input_qual_selector_low;
			GPC_OFS_QSEL_HIGH: next_hrdata = {16'h0000, input_qual_selector_high};
			GPC_OFS_QUAL_CTRL: next_hrdata = {8'h00, port_qual_control};
			default: next_hrdata = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata <= 32'h0000_0000;
		end else if (addr_valid && !hwrite) begin
			hrdata <= next_hrdata;
		end
	end

	// function select registers
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			portc_function_select_low <= GPC_RST_FSEL_LOW;
			portc_function_select_high <= GPC_RST_FSEL_HIGH;
		end else if (wr_pend) begin
			if (wr_addr == GPC_OFS_FSEL_LOW) portc_function_select_low <= hwdata;
			if (wr_addr == GPC_OFS_FSEL_HIGH) portc_function_select_high <= hwdata[15:0];
		end
	end

	// direction and output latch
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			portc_direction <= GPC_RST_DIRECTION;
			portc_out_latch <= GPC_RST_DOUT;
		end else if (wr_pend) begin
			if (wr_addr == GPC_OFS_DIRECTION) portc_direction <= hwdata[GPC_NPINS-1:0];
			if (wr_addr == GPC_OFS_PIN_VALUE) portc_out_latch <= hwdata[GPC_NPINS-1:0];
		end
	end

	// qualification selectors and periods
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			input_qual_selector_low <= GPC_RST_QSEL_LOW;
			input_qual_selector_high <= GPC_RST_QSEL_HIGH;
			port_qual_control <= GPC_RST_QUAL_CTRL;
		end else if (wr_pend) begin
			if (wr_addr == GPC_OFS_QSEL_LOW) input_qual_selector_low <= hwdata;
			if (wr_addr == GPC_OFS_QSEL_HIGH) input_qual_selector_high <= hwdata[15:0];
			if (wr_addr == GPC_OFS_QUAL_CTRL) begin
				port_qual_control <= hwdata[GPC_NGROUPS*GPC_PRD_WIDTH-1:0];
			end
		end
	end

	assign qsel_all = {input_qual_selector_high, input_qual_selector_low};

	// two-stage synchroniser on every pin
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			sync1 <= '0;
			sync2 <= '0;
		end else begin
			sync1 <= pin_in;
			sync2 <= sync1;
		end
	end

	// per-group sample tick counters
	generate
		for (genvar g = 0; g < GPC_NGROUPS; g++) begin : g_tick
			logic [GPC_PRD_WIDTH-1:0] prd;
			logic [GPC_PRD_WIDTH:0] cnt;
			assign prd = port_qual_control[GPC_PRD_POS0 + g*GPC_PRD_WIDTH +: GPC_PRD_WIDTH];
			always_ff @(posedge hclk or negedge hresetn) begin
				if (!hresetn) begin
					cnt <= '0;
				end else if (cnt + 1'b1 >= interval(prd)) begin
					cnt <= '0;
				end else begin
					cnt <= cnt + 1'b1;
				end
			end
			assign grp_tick[g] = (cnt + 1'b1 >= interval(prd));
		end
	endgenerate

	// qualifier per pin
	generate
		for (genvar p = 0; p < GPC_NPINS; p++) begin : g_pin
			gpc_qualifier u_qual (
				.hclk(hclk),
				.hresetn(hresetn),
				.sync_in(sync2[p]),
				.raw_in(pin_in[p]),
				.qmode(qsel_all[2*p +: 2]),
				.sample_tick(grp_tick[p / GPC_GROUP]),
				.qual_out(portc_pin_value[p])
			);
		end
	endgenerate

	// external function selects from the upper bit of each field
	always_comb begin
		for (int n = 0; n < GPC_NDATA; n++) begin
			ext_sel[n] = field2(portc_function_select_low, n) >= 2'h2;
		end
		for (int k = 0; k < GPC_NADDR; k++) begin
			ext_sel[GPC_NDATA + k] = field2({16'h0000, portc_function_select_high}, k) >= 2'h2;
		end
	end

	// data-line pins: bidirectional external data or gpio; address-line pins: external address or gpio
	always_comb begin
		for (int n = 0; n < GPC_NDATA; n++) begin
			if (ext_sel[n]) begin
				pin_out[n] = ext_bus_data_line_out[GPC_NDATA-1-n];
				pin_oe_n[n] = ~ext_bus_data_drive;
			end else begin
				pin_out[n] = portc_out_latch[n];
				pin_oe_n[n] = ~portc_direction[n];
			end
		end
		for (int k = 0; k < GPC_NADDR; k++) begin
			if (ext_sel[GPC_NDATA + k]) begin
				pin_out[GPC_NDATA + k] = ext_bus_addr_line[k];
				pin_oe_n[GPC_NDATA + k] = 1'b0;
			end else begin
				pin_out[GPC_NDATA + k] = portc_out_latch[GPC_NDATA + k];
				pin_oe_n[GPC_NDATA + k] = ~portc_direction[GPC_NDATA + k];
			end
		end
	end

	// bus controller data inputs: synchronised pin when routed, default otherwise
	always_comb begin
		for (int n = 0; n < GPC_NDATA; n++) begin
			if (ext_sel[n]) begin
				ext_bus_data_line_in[GPC_NDATA-1-n] = sync2[n];
			end else begin
				ext_bus_data_line_in[GPC_NDATA-1-n] = GPC_XD_DEFAULT[GPC_NDATA-1-n];
			end
		end
	end
endmodule : gpc_port

// >>> testbench/gpc_port_checker.sv
// port-level assertions for the port c block
module gpc_port_checker
	import gpc_pkg::*;
(
	// bus
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	input wire logic [31:0] hrdata,
	input wire logic hreadyout,
	input wire logic hresp,
	// pins and bus controller
	input wire logic [GPC_NPINS-1:0] pin_in,
	input wire logic [GPC_NPINS-1:0] pin_out,
	input wire logic [GPC_NPINS-1:0] pin_oe_n,
	input wire logic [GPC_NDATA-1:0] ext_bus_data_line_out,
	input wire logic ext_bus_data_drive,
	input wire logic [GPC_NDATA-1:0] ext_bus_data_line_in,
	input wire logic [GPC_NADDR-1:0] ext_bus_addr_line
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	logic ap_w;
	logic [7:0] ap_a;
	logic [31:0] sh_lo;
	logic [15:0] sh_hi;
	logic [15:0] lo_m;
	logic [7:0] hi_m;
	logic [15:0] dout_r;
	logic [15:0] din_r;
	assign dout_r = {<<{ext_bus_data_line_out}};
	assign din_r = {<<{ext_bus_data_line_in}};
	always_comb begin
		for (int i = 0; i < 16; i++) lo_m[i] = sh_lo[2*i+1];
		for (int i = 0; i < 8; i++) hi_m[i] = sh_hi[2*i+1];
	end
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ap_w <= 1'b0;
			ap_a <= 8'h00;
			sh_lo <= 32'h0;
			sh_hi <= 16'h0;
		end else begin
			ap_w <= hsel && htrans[1] && hwrite && hready;
			ap_a <= haddr[7:0];
			if (ap_w && ap_a == GPC_OFS_FSEL_LOW) sh_lo <= hwdata;
			if (ap_w && ap_a == GPC_OFS_FSEL_HIGH) sh_hi <= hwdata[15:0];
		end
	end
	a_ready_high: assert property (hreadyout)
		else $error("hreadyout low");
	a_resp_okay: assert property (!hresp)
		else $error("hresp not okay");
	a_reset_input: assert property ($rose(hresetn) |-> &pin_oe_n && pin_out == '0)
		else $error("pins not inputs after reset");
	a_addr_route: assert property (((pin_out[23:16] ^ ext_bus_addr_line) & hi_m) == 0
		&& (pin_oe_n[23:16] & hi_m) == 0) else $error("address line routing wrong");
	a_data_route: assert property (((pin_out[15:0] ^ dout_r) & lo_m) == 0
		&& ((pin_oe_n[15:0] ^ {16{!ext_bus_data_drive}}) & lo_m) == 0)
		else $error("data line routing wrong");
	a_data_default: assert property ((din_r & ~lo_m) == 0)
		else $error("unrouted data line not at default");
	a_data_sync: assert property (((din_r ^ $past(pin_in[15:0], 2)) & lo_m) == 0)
		else $error("data line input not two-flop synchronised");
	a_rdata_hold: assert property (!$past(hsel && htrans[1] && !hwrite && hready)
		|-> $stable(hrdata)) else $error("hrdata changed without read");
endmodule : gpc_port_checker

bind gpc_port gpc_port_checker chk_u (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
	.hwdata, .hready, .hrdata, .hreadyout, .hresp, .pin_in, .pin_out, .pin_oe_n,
	.ext_bus_data_line_out, .ext_bus_data_drive, .ext_bus_data_line_in, .ext_bus_addr_line);

// >>> testbench/gpc_board.sv
// board model: a pad follows the block when enabled, else the board level
module gpc_board
	import gpc_pkg::*;
(
	// block side
	input wire logic [GPC_NPINS-1:0] pin_out,
	input wire logic [GPC_NPINS-1:0] pin_oe_n,
	// board side
	input wire logic [GPC_NPINS-1:0] board_level,
	output logic [GPC_NPINS-1:0] pin_in
);
	timeunit 1ns;
	timeprecision 1ps;
	assign pin_in = (pin_out & ~pin_oe_n) | (board_level & pin_oe_n);
endmodule : gpc_board

// >>> testbench/test_gpc_port.sv
// testbench for the port c mux and input qualification block
module test_gpc_port;
	timeunit 1ns;
	timeprecision 1ps;
	import gpc_pkg::*;
	`define CHK(nm, e, s) begin checks++; if ((s) !== (e)) begin n_fail++; \
		$display("CHECK FAILED %s exp %h got %h", nm, e, s); end end
	logic hclk = 1'b0;
	logic hresetn = 1'b0;
	logic hsel = 1'b0;
	logic hwrite = 1'b0;
	logic drv = 1'b0;
	logic dph = 1'b0;
	logic [1:0] htrans = 2'h0;
	logic [31:0] haddr = '0;
	logic [31:0] hwdata = '0;
	logic [31:0] hrdata, ev, r;
	logic hreadyout, hresp;
	logic [23:0] pin_in, pin_out, pin_oe_n;
	logic [23:0] lvl = '0;
	logic [15:0] dout = '0;
	logic [15:0] din;
	logic [7:0] addr = '0;
	logic [31:0] q[$];
	logic [7:0] ofs[5] = '{8'h00, 8'h04, 8'h10, 8'h14, 8'h18};
	logic [31:0] msk[5] = '{32'hffffffff, 32'hffff, 32'hffffffff, 32'hffff, 32'hffffff};
	int n_fail = 0;
	int checks = 0;
	int seed = 84090;
	always #5 hclk = ~hclk;
	gpc_port dut_u (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
		.hready(hreadyout), .hrdata, .hreadyout, .hresp, .pin_in, .pin_out, .pin_oe_n,
		.ext_bus_data_line_out(dout), .ext_bus_data_drive(drv), .ext_bus_data_line_in(din),
		.ext_bus_addr_line(addr));
	gpc_board brd_u (.pin_out, .pin_oe_n, .board_level(lvl), .pin_in);
	always @(posedge hclk) begin
		dout <= 16'($random(seed));
		addr <= 8'($random(seed));
		drv <= 1'($random(seed));
	end
	always @(posedge hclk) begin
		if (dph) begin
			ev = q.pop_front();
			`CHK("hrdata", ev, hrdata)
		end
		dph = hsel && htrans[1] && !hwrite && hreadyout;
	end
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		hwrite <= w;
		haddr <= {24'h0, a};
		htrans <= 2'h2;
		if (!w) q.push_back(d);
		do @(posedge hclk); while (!hreadyout);
		htrans <= 2'h0;
		hwdata <= w ? d : 32'h0;
		do @(posedge hclk); while (!hreadyout);
	endtask : bus
	task automatic end_sim();
		$display("checks %0d n_fail %0d", checks, n_fail);
		if (n_fail == 0 && checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : end_sim
	initial begin
		#100000;
		n_fail++;
		end_sim();
	end
	initial begin
		repeat (2) @(posedge hclk);
		hresetn <= 1'b1;
		for (int a = 0; a < 36; a += 4) bus(0, 8'(a), 0);
		foreach (ofs[i]) begin
			r = $random(seed);
			bus(1, ofs[i], r);
			bus(0, ofs[i], r & msk[i]);
		end
		bus(1, GPC_OFS_FSEL_LOW, 32'h5555_5555);
		bus(1, GPC_OFS_FSEL_HIGH, 0);
		bus(1, GPC_OFS_QSEL_LOW, 0);
		bus(1, GPC_OFS_QSEL_HIGH, 0);
		repeat (4) begin
			lvl <= 24'($random(seed));
			repeat (3) @(posedge hclk);
			bus(0, GPC_OFS_PIN_VALUE, {8'h0, lvl});
		end
		bus(1, GPC_OFS_QSEL_LOW, '1);
		bus(1, GPC_OFS_QSEL_HIGH, 32'hffff);
		lvl <= ~lvl;
		bus(0, GPC_OFS_PIN_VALUE, {8'h0, ~lvl});
		lvl <= '0;
		bus(1, GPC_OFS_QSEL_LOW, 32'haaaa_5555);
		bus(1, GPC_OFS_QSEL_HIGH, 32'h5555);
		bus(1, GPC_OFS_QUAL_CTRL, 32'h0603);
		repeat (100) @(posedge hclk);
		lvl <= '1;
		repeat (2) @(posedge hclk);
		lvl <= '0;
		repeat (3) @(posedge hclk);
		bus(0, GPC_OFS_PIN_VALUE, 0);
		repeat (15) @(posedge hclk);
		lvl <= '1;
		repeat (10) @(posedge hclk);
		bus(0, GPC_OFS_PIN_VALUE, 32'hff_0000);
		repeat (18) @(posedge hclk);
		bus(0, GPC_OFS_PIN_VALUE, 32'hff_00ff);
		repeat (58) @(posedge hclk);
		bus(0, GPC_OFS_PIN_VALUE, 32'hff_ffff);
		bus(1, GPC_OFS_QSEL_LOW, 0);
		bus(1, GPC_OFS_QSEL_HIGH, 0);
		r = $random(seed);
		bus(1, GPC_OFS_DIRECTION, '1);
		bus(1, GPC_OFS_PIN_VALUE, r);
		repeat (3) @(posedge hclk);
		bus(0, GPC_OFS_PIN_VALUE, {8'h0, r[23:0]});
		bus(1, GPC_OFS_FSEL_LOW, 32'haaaa_aaaa);
		bus(1, GPC_OFS_FSEL_HIGH, 32'haaaa);
		repeat (20) @(posedge hclk);
		bus(1, GPC_OFS_FSEL_LOW, 32'h0000_aaaa);
		bus(1, GPC_OFS_FSEL_HIGH, 32'h00aa);
		repeat (20) @(posedge hclk);
		hresetn <= 1'b0;
		repeat (2) @(posedge hclk);
		hresetn <= 1'b1;
		bus(0, GPC_OFS_FSEL_LOW, 0);
		@(posedge hclk);
		end_sim();
	end
endmodule : test_gpc_port
